// File: design/rwwc_ctrl.v
// Reset, sleep, wake-up, timer/counter and watchdog control.
//
// Summary of operation
// (R1) Two 8-bit prescalers, timer and watchdog, each ratio set by 3 bits.
// (R2) Writing the timer/counter value clears the timer prescaler.
// (R3) Watchdog-clear or sleep instruction clears watchdog counter and prescaler.
// (R4) Timer/counter is an 8-bit up-counter on the internal instruction clock.
// (R5) Timer/counter stops while sleeping.
// (R6) Watchdog keeps counting in sleep; enabled time-out resets the device.
// (R7) Watchdog enable may change anytime in normal mode, taking effect at once.
// (R8) Unprescaled watchdog time-out is about 18 ms.
// (R9) Reset from power-on, reset pin low, watchdog time-out or low-volt reset.
// (R10) Reset held about 18 ms, or 8/32 clocks with internal RC.
// (R11) Reset keeps oscillator, zeroes program counter, floats pins, clears watchdog.
// (R12) Sleep instruction powers down; watchdog cleared on entry, keeps counting.
// (R13) With internal RC, leaving sleep waits 8 or 32 clocks.
// (R14) Sleep exits on pin, watchdog, ext pin, port, serial, low-volt, conversion.
// (R15) Pin and watchdog wakes reset and set cause flags; others continue.
// (R16) Non-reset wake vectors if interrupts were on, else resumes next.
// (R17) Software enables one wake source; enabled watchdog limits wake sources.
// (R18) Software disables watchdog before low-volt or conversion wake.
// (R19) Serial or two-wire slave receive wakes the device when enabled.
// (R20) Port-change wake sequence by software; enabled interrupts vector to 0006H.
// (R21) Ext pin wakes only with both enables; timer interrupt wakes only idle.
// (R22) Time-out and power-down flags follow power-on, clear, time-out, sleep, wake.
// (R23) Every wake request is gated by its own enable; the reset pin ends sleep with no enable.
`timescale 1ns/1ps
`include "rwwc_regs.vh"
module rwwc_ctrl #(
  parameter [`RWWC_TIME_W-1:0] RST_HOLD_CYC    = `RWWC_HOLD_CYC,
  parameter [`RWWC_TIME_W-1:0] WDT_TIMEOUT_CYC = `RWWC_WDT_CYC
) (
  // Clock and reset
  input  wire                   ref_clk,
  input  wire                   rst_b,
  // Reset sources
  input  wire                   reset_pin_b,
  input  wire                   low_volt_reset_en,
  input  wire                   low_volt_reset,
  // Oscillator options
  input  wire                   internal_rc_osc,
  input  wire                   internal_rc_long,
  // Instructions from the core, one-cycle strobes
  input  wire                   sleep_instr,
  input  wire                   idle_instr,
  input  wire                   watchdog_clear_instr,
  input  wire                   global_irq_on_instr,
  input  wire                   global_irq_off_instr,
  // Timer/counter control and data
  input  wire                   timer_prescale_en,
  input  wire [`RWWC_SEL_W-1:0] timer_prescale_select,
  input  wire                   timer_value_wr,
  input  wire [`RWWC_TCC_W-1:0] timer_value_wdata,
  // Watchdog control
  input  wire                   watchdog_enable_bit,
  input  wire                   watchdog_prescale_en,
  input  wire [`RWWC_SEL_W-1:0] watchdog_prescale_select,
  // Wake enables
  input  wire                   ext_pin_wake_enable,
  input  wire                   ext_pin_irq_enable,
  input  wire                   port_change_wake_enable,
  input  wire                   serial_slave_wake_enable,
  input  wire                   twowire_slave_wake_enable,
  input  wire                   low_volt_wake_enable,
  input  wire                   conversion_done_wake_enable,
  input  wire                   timer_counter_irq_enable,
  // Wake events
  input  wire                   ext_pin_change,
  input  wire                   port_change,
  input  wire                   serial_slave_rx,
  input  wire                   twowire_slave_rx,
  input  wire                   low_volt_detect,
  input  wire                   conversion_done,
  // Core control
  output reg                    core_reset,
  output reg                    core_run,
  output reg                    io_float,
  output reg                    osc_enable,
  output reg                    sleep_mode,
  output reg                    idle_mode,
  output reg                    wake_vector,
  output reg  [11:0]            wake_vector_addr,
  output reg                    wake_resume,
  // Status flags and timer
  output reg                    timeout_flag,
  output reg                    powerdown_flag,
  output reg  [`RWWC_TCC_W-1:0] timer_counter_value,
  output reg                    timer_overflow
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] ST_HOLD  = 3'h0;
  localparam [2:0] ST_RUN   = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_IDLE  = 3'h3;
  localparam [2:0] ST_WAKE  = 3'h4;

  reg  [2:0]               state_reg;
  reg  [2:0]               state_next;
  reg                      load_pend_reg;
  reg                      gie_reg;
  reg  [`RWWC_TIME_W-1:0]  wdt_cnt_reg;
  wire                     tcc_tick;
  wire                     wdt_tick;
  wire                     wdt_clear;
  wire                     wdt_timeout;
  wire                     reset_req;
  wire                     wake_req;
  wire                     hold_busy;
  wire                     hold_load;
  wire [`RWWC_TIME_W-1:0]  hold_len;
  wire [`RWWC_TIME_W-1:0]  irc_len;
  wire                     in_run;
  wire                     do_sleep;

  // --------------------------------------------------------------------
  // Reset and wake qualification
  // --------------------------------------------------------------------
  assign in_run      = (state_reg == ST_RUN);
  assign do_sleep    = in_run & sleep_instr;
  assign wdt_timeout = watchdog_enable_bit & wdt_tick &
                       (wdt_cnt_reg == WDT_TIMEOUT_CYC -
                        {{(`RWWC_TIME_W-1){1'b0}}, 1'b1}); // (R6) (R8)
  assign reset_req   = ~reset_pin_b | wdt_timeout |
                       (low_volt_reset_en & low_volt_reset); // (R9) (R15)
  // A disabled source never ends sleep, whatever its event line does.
  assign wake_req    = (ext_pin_wake_enable & ext_pin_irq_enable &
                        ext_pin_change) |                    // (R21) (R23)
                       (port_change_wake_enable & port_change) |
                       (serial_slave_wake_enable & serial_slave_rx) |
                       (twowire_slave_wake_enable & twowire_slave_rx) |
                       (low_volt_wake_enable & low_volt_detect) |
                       (conversion_done_wake_enable &
                        conversion_done);                    // (R14) (R19)
  assign irc_len     = internal_rc_long ? `RWWC_IRC_LONG_CYC
                                        : `RWWC_IRC_SHORT_CYC;
  assign hold_len    = internal_rc_osc ? irc_len : RST_HOLD_CYC; // (R10)
  assign hold_load   = reset_req | load_pend_reg |
                       (state_reg == ST_SLEEP & wake_req) |
                       (state_reg == ST_IDLE & (wake_req |
                        (timer_counter_irq_enable & tcc_tick &
                         (&timer_counter_value))));          // (R13)

  rwwc_hold_timer #(
    .W        (`RWWC_TIME_W)
  ) u_hold (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .load     (hold_load),
    .load_val (hold_len),
    .busy     (hold_busy)
  );

  // --------------------------------------------------------------------
  // Timer/counter and its prescaler
  // --------------------------------------------------------------------
  rwwc_prescaler #(
    .W        (`RWWC_PRESC_W)
  ) u_tcc_psc (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clr      (timer_value_wr | core_reset),                 // (R2)
    .tick_in  (state_reg != ST_SLEEP),                       // (R5)
    .bypass   (~timer_prescale_en),
    .sel      (timer_prescale_select),                       // (R1)
    .tick_out (tcc_tick)
  );

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_counter_value <= {`RWWC_TCC_W{1'b0}};
      timer_overflow      <= 1'b0;
    end else if (timer_value_wr) begin
      timer_counter_value <= timer_value_wdata;
      timer_overflow      <= 1'b0;
    end else begin
      timer_overflow <= tcc_tick & (&timer_counter_value);
      if (tcc_tick) begin
        timer_counter_value <= timer_counter_value +
                               {{(`RWWC_TCC_W-1){1'b0}}, 1'b1}; // (R4)
      end
    end
  end

  // --------------------------------------------------------------------
  // Watchdog and its prescaler
  // --------------------------------------------------------------------
  // The watchdog runs on every edge, asleep or awake; only its enable
  // level and the reset hold stop it, and that level is honoured in the same cycle.
  assign wdt_clear = (in_run & (watchdog_clear_instr | sleep_instr)) |
                     (state_reg == ST_HOLD);                 // (R3) (R11) (R12)

  rwwc_prescaler #(
    .W        (`RWWC_PRESC_W)
  ) u_wdt_psc (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clr      (wdt_clear),                                   // (R3)
    .tick_in  (watchdog_enable_bit),                         // (R7)
    .bypass   (~watchdog_prescale_en),
    .sel      (watchdog_prescale_select),                    // (R1)
    .tick_out (wdt_tick)
  );

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_cnt_reg <= {`RWWC_TIME_W{1'b0}};
    end else if (wdt_clear | wdt_timeout) begin
      wdt_cnt_reg <= {`RWWC_TIME_W{1'b0}};
    end else if (wdt_tick) begin
      wdt_cnt_reg <= wdt_cnt_reg + {{(`RWWC_TIME_W-1){1'b0}}, 1'b1}; // (R6)
    end
  end

  // --------------------------------------------------------------------
  // Operating state
  // --------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (!hold_busy && !load_pend_reg && !reset_req) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_instr) begin
          state_next = ST_SLEEP;                             // (R12)
        end else if (idle_instr) begin
          state_next = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (wake_req) begin
          state_next = ST_WAKE;                              // (R14)
        end
      end
      ST_IDLE: begin
        if (hold_load) begin
          state_next = ST_WAKE;                              // (R21)
        end
      end
      ST_WAKE: begin
        if (!hold_busy) begin
          state_next = ST_RUN;                               // (R13)
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
    if (reset_req) begin
      state_next = ST_HOLD;                                  // (R9) (R15)
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_HOLD;
      load_pend_reg <= 1'b1;
    end else begin
      state_reg     <= state_next;
      load_pend_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Global interrupt state seen at wake time
  // --------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gie_reg <= 1'b0;
    end else if (state_next == ST_HOLD) begin
      gie_reg <= 1'b0;
    end else if (global_irq_on_instr) begin
      gie_reg <= 1'b1;
    end else if (global_irq_off_instr) begin
      gie_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reset       <= 1'b1;
      core_run         <= 1'b0;
      io_float         <= 1'b1;
      osc_enable       <= 1'b1;
      sleep_mode       <= 1'b0;
      idle_mode        <= 1'b0;
      wake_vector      <= 1'b0;
      wake_vector_addr <= `RWWC_IRQ_VECTOR;
      wake_resume      <= 1'b0;
    end else begin
      core_reset       <= (state_next == ST_HOLD);           // (R11)
      io_float         <= (state_next == ST_HOLD);           // (R11)
      core_run         <= (state_next == ST_RUN);
      // The oscillator driver stops only in sleep; reset keeps it going.
      osc_enable       <= (state_next != ST_SLEEP);          // (R11) (R12)
      sleep_mode       <= (state_next == ST_SLEEP);
      idle_mode        <= (state_next == ST_IDLE);
      wake_vector_addr <= `RWWC_IRQ_VECTOR;                  // (R20)
      wake_vector      <= (state_reg == ST_WAKE) &
                          (state_next == ST_RUN) & gie_reg;  // (R16)
      wake_resume      <= (state_reg == ST_WAKE) &
                          (state_next == ST_RUN) & ~gie_reg; // (R16)
    end
  end

  // --------------------------------------------------------------------
  // Time-out and power-down flags
  // --------------------------------------------------------------------
  // A reset from the pin leaves both flags as they were, so a pin reset
  // during sleep still reads the values that the sleep entry wrote.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_flag   <= 1'b1;                                // (R22)
      powerdown_flag <= 1'b1;
    end else if (wdt_timeout) begin
      timeout_flag   <= 1'b0;                                // (R15) (R22)
    end else if (do_sleep) begin
      timeout_flag   <= 1'b1;                                // (R22)
      powerdown_flag <= 1'b0;
    end else if (in_run & watchdog_clear_instr) begin
      timeout_flag   <= 1'b1;                                // (R22)
      powerdown_flag <= 1'b1;
    end else if (state_reg == ST_SLEEP & wake_req) begin
      timeout_flag   <= 1'b1;                                // (R22)
      powerdown_flag <= 1'b0;
    end
  end

endmodule

// File: design/rwwc_hold_timer.v
// Down-counter that times the reset hold and the wake-up delay.
`timescale 1ns/1ps
`include "rwwc_regs.vh"
module rwwc_hold_timer #(
  parameter W = `RWWC_TIME_W
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst_b,
  // Load
  input  wire         load,
  input  wire [W-1:0] load_val,
  // Status
  output wire         busy
);

  reg [W-1:0] cnt_reg;

  assign busy = (cnt_reg != {W{1'b0}});

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= {W{1'b0}};
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (busy) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// File: design/rwwc_prescaler.v
// Eight-bit ratio prescaler shared by the timer/counter and the watchdog.
`timescale 1ns/1ps
`include "rwwc_regs.vh"
module rwwc_prescaler #(
  parameter W = `RWWC_PRESC_W
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst_b,
  // Control
  input  wire         clr,
  input  wire         tick_in,
  input  wire         bypass,
  input  wire [2:0]   sel,
  // Divided tick
  output wire         tick_out
);

  reg  [W-1:0] cnt_reg;
  wire [W-1:0] mask;

  // Ratio is two to the power sel plus one, so sel 7 spans all eight bits.
  assign mask     = ({{(W-1){1'b0}}, 1'b1} << sel) |
                    (({{(W-1){1'b0}}, 1'b1} << sel) - {{(W-1){1'b0}}, 1'b1});
  assign tick_out = tick_in & (bypass | ((cnt_reg & mask) == mask));

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= {W{1'b0}};
    end else if (clr) begin
      cnt_reg <= {W{1'b0}};
    end else if (tick_in) begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// File: design/rwwc_regs.vh
// Timing and field constants for the reset, wake-up and watchdog control.
`ifndef RWWC_REGS_VH
`define RWWC_REGS_VH

// ----------------------------------------------------------------------
// Clock and time bases
// ----------------------------------------------------------------------
`define RWWC_CLK_KHZ        23'd250000
`define RWWC_HOLD_MS        23'd18
`define RWWC_WDT_MS         23'd18
`define RWWC_HOLD_CYC       (`RWWC_HOLD_MS * `RWWC_CLK_KHZ)
`define RWWC_WDT_CYC        (`RWWC_WDT_MS * `RWWC_CLK_KHZ)
`define RWWC_IRC_SHORT_CYC  23'h000008
`define RWWC_IRC_LONG_CYC   23'h000020
`define RWWC_TIME_W         23

// ----------------------------------------------------------------------
// Prescaler and counter widths, vector address
// ----------------------------------------------------------------------
`define RWWC_PRESC_W        8
`define RWWC_SEL_W          3
`define RWWC_TCC_W          8
`define RWWC_IRQ_VECTOR     12'h006

`endif

// File: dv/rwwc_core_model.sv
// Behavioural CPU core that issues one-cycle instruction strobes.
`timescale 1ns/1ps
module rwwc_core_model (
  // Clock and run status
  input  wire ref_clk,
  input  wire core_run,
  // Instruction strobes
  output wire sleep_instr,
  output wire idle_instr,
  output wire watchdog_clear_instr,
  output wire global_irq_on_instr,
  output wire global_irq_off_instr
);
  logic [4:0] op_reg = 5'h00;
  assign {global_irq_off_instr, global_irq_on_instr, watchdog_clear_instr,
          idle_instr, sleep_instr} = op_reg;
  // Opcodes: 0 sleep, 1 idle, 2 clear, 3 irq on, 4 irq off. A halted core
  // executes nothing, so each strobe waits for the run state.
  task automatic exec(input int op);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (core_run !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    op_reg = 5'h01 << op;
    @(negedge ref_clk);
    op_reg = 5'h00;
  endtask
endmodule

// File: dv/rwwc_ctrl_monitor.sv
// Port-level assertions for the reset, sleep and wake-up controller.
`timescale 1ns/1ps
module rwwc_ctrl_monitor #(
  parameter int RST_HOLD_CYC    = 40,
  parameter int WDT_TIMEOUT_CYC = 64
) (
  // Clock, reset and reset sources
  input wire        ref_clk, rst_b, reset_pin_b,
  input wire        low_volt_reset_en, low_volt_reset,
  input wire        internal_rc_osc, internal_rc_long,
  // Instructions and timer control
  input wire        sleep_instr, watchdog_clear_instr, watchdog_enable_bit,
  input wire        timer_prescale_en, timer_value_wr,
  input wire [7:0]  timer_value_wdata, timer_counter_value,
  // Wake enables and events
  input wire        ext_pin_wake_enable, ext_pin_irq_enable,
  input wire        port_change_wake_enable, serial_slave_wake_enable,
  input wire        twowire_slave_wake_enable, low_volt_wake_enable,
  input wire        conversion_done_wake_enable,
  input wire        ext_pin_change, port_change, serial_slave_rx,
  input wire        twowire_slave_rx, low_volt_detect, conversion_done,
  // Core control and flags
  input wire        core_reset, core_run, io_float, osc_enable, sleep_mode,
  input wire        wake_vector, wake_resume, timeout_flag, powerdown_flag,
  input wire [11:0] wake_vector_addr
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // No reset source can interfere while this holds.
  wire quiet = reset_pin_b & ~watchdog_enable_bit
               & ~(low_volt_reset_en & low_volt_reset);
  wire wake_req = (ext_pin_wake_enable & ext_pin_irq_enable & ext_pin_change)
    | (port_change_wake_enable & port_change)
    | (serial_slave_wake_enable & serial_slave_rx)
    | (twowire_slave_wake_enable & twowire_slave_rx)
    | (low_volt_wake_enable & low_volt_detect)
    | (conversion_done_wake_enable & conversion_done);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sleep_entry_a: assert property (sleep_instr && core_run && quiet
    |=> sleep_mode && !osc_enable && !core_run && timeout_flag
        && !powerdown_flag) else $error("sleep entry outputs wrong");
  timer_halt_a: assert property (sleep_mode [*2]
    |-> $stable(timer_counter_value)) else $error("timer moved in sleep");
  timer_step_a: assert property (core_run && quiet && !timer_prescale_en
    && !timer_value_wr && !sleep_instr |=> timer_counter_value
    == $past(timer_counter_value) + 8'h01) else $error("timer step wrong");
  timer_load_a: assert property (timer_value_wr && core_run && quiet
    |=> timer_counter_value == $past(timer_value_wdata))
    else $error("timer load wrong");
  wake_gate_a: assert property (sleep_mode && quiet && !wake_req
    |=> sleep_mode) else $error("sleep left without enabled source");
  wake_delay_a: assert property ($fell(sleep_mode) && !core_reset
    && internal_rc_osc && !internal_rc_long |-> !core_run [*8] ##1 !core_run
    ##1 (core_run && (wake_vector ^ wake_resume))) else $error("wake delay");
  vector_addr_a: assert property (wake_vector
    |-> wake_vector_addr == 12'h006 && !wake_resume)
    else $error("vector address wrong");
  wake_pulse_a: assert property (wake_vector || wake_resume
    |=> !wake_vector && !wake_resume) else $error("wake pulse too long");
  pin_reset_a: assert property (!reset_pin_b
    |-> ##[1:2] (core_reset && io_float && !core_run && osc_enable))
    else $error("pin reset not taken");
  hold_time_a: assert property ($rose(reset_pin_b) && internal_rc_osc
    && !internal_rc_long |-> !core_run [*8] ##[1:4] core_run)
    else $error("reset hold length wrong");
  wdt_flag_a: assert property ($fell(timeout_flag)
    |-> ##[0:1] core_reset) else $error("time-out without reset");
  wdt_clear_a: assert property (watchdog_clear_instr && core_run
    && reset_pin_b && !sleep_instr |=> timeout_flag && powerdown_flag)
    else $error("clear flags wrong");
endmodule

bind rwwc_ctrl rwwc_ctrl_monitor #(
  .RST_HOLD_CYC(RST_HOLD_CYC), .WDT_TIMEOUT_CYC(WDT_TIMEOUT_CYC)
) u_rwwc_ctrl_monitor (.*);

// File: dv/test_reset_wakeup_watchdog_control.sv
// Self-checking testbench for the reset, sleep and wake-up controller.
`timescale 1ns/1ps
module test_reset_wakeup_watchdog_control;
  logic       ref_clk, rst_b, reset_pin_b, low_volt_reset_en, low_volt_reset;
  logic       internal_rc_osc, internal_rc_long, timer_counter_irq_enable;
  logic       timer_prescale_en, timer_value_wr, watchdog_enable_bit;
  logic       watchdog_prescale_en, ext_pin_irq_enable;
  logic [2:0] timer_prescale_select, watchdog_prescale_select;
  logic [7:0] timer_value_wdata;
  logic [5:0] wen, wev;
  wire  sleep_instr, idle_instr, watchdog_clear_instr;
  wire  global_irq_on_instr, global_irq_off_instr;
  wire  ext_pin_wake_enable, port_change_wake_enable, serial_slave_wake_enable;
  wire  twowire_slave_wake_enable, low_volt_wake_enable;
  wire  conversion_done_wake_enable, ext_pin_change, port_change;
  wire  serial_slave_rx, twowire_slave_rx, low_volt_detect, conversion_done;
  wire  core_reset, core_run, io_float, osc_enable, sleep_mode, idle_mode;
  wire  wake_vector, wake_resume, timeout_flag, powerdown_flag;
  wire  timer_overflow;
  wire [11:0] wake_vector_addr;
  wire [7:0]  timer_counter_value;
  int miscompares = 0;
  int n_checks = 0;
  assign {conversion_done_wake_enable, low_volt_wake_enable,
          twowire_slave_wake_enable, serial_slave_wake_enable,
          port_change_wake_enable, ext_pin_wake_enable} = wen;
  assign {conversion_done, low_volt_detect, twowire_slave_rx,
          serial_slave_rx, port_change, ext_pin_change} = wev;
  rwwc_ctrl #(.RST_HOLD_CYC(23'h000028), .WDT_TIMEOUT_CYC(23'h000040))
    u_rwwc_ctrl (.*);
  rwwc_core_model u_rwwc_core_model (.*);
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Waits for run (sel 0) or a wake pulse (sel 1), bounded.
  task automatic wait_for(input int sel, output int n);
    n = 0;
    while ((sel ? (wake_vector | wake_resume) : core_run) !== 1'b1
           && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 300, 1'b1);
  endtask
  task automatic wr_tcc(input logic [7:0] v);
    timer_value_wdata = v;
    timer_value_wr = 1'b1;
    cyc(1);
    timer_value_wr = 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #60000;
    miscompares++;
    end_sim();
  end
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    int n;
    {rst_b, low_volt_reset_en, low_volt_reset, internal_rc_long} = 4'h0;
    {reset_pin_b, internal_rc_osc, timer_value_wr} = 3'b110;
    {timer_prescale_en, watchdog_enable_bit, watchdog_prescale_en} = 3'b000;
    {ext_pin_irq_enable, timer_counter_irq_enable} = 2'b00;
    {timer_prescale_select, watchdog_prescale_select} = 6'h00;
    {timer_value_wdata, wen, wev} = 20'h00000;
    cyc(3);
    chk({core_reset, io_float, osc_enable, core_run, timeout_flag,
         powerdown_flag}, 12'h03b);
    rst_b = 1'b1;
    wait_for(0, n);
    chk(n inside {[8:12]}, 1'b1);
    chk({core_reset, io_float}, 2'b00);
    $display("power-on test done");
    wr_tcc(8'hfe);
    chk(timer_counter_value, 8'hfe);
    cyc(1);
    chk(timer_counter_value, 8'hff);
    cyc(1);
    chk({timer_counter_value, timer_overflow}, 9'h001);
    timer_prescale_en = 1'b1;
    for (int s = 0; s < 3; s++) begin
      timer_prescale_select = s[2:0];
      wr_tcc(8'h00);
      cyc(16);
      chk(timer_counter_value, 8'h10 >> (s + 1));
    end
    timer_prescale_en = 1'b0;
    $display("timer test done");
    u_rwwc_core_model.exec(4);
    u_rwwc_core_model.exec(0);
    chk({sleep_mode, osc_enable, core_run, timeout_flag, powerdown_flag},
        5'h12);
    n = timer_counter_value;
    cyc(20);
    chk(timer_counter_value, n[7:0]);
    wev = 6'h3f;
    cyc(4);
    chk(sleep_mode, 1'b1);
    wen = 6'h01;
    cyc(4);
    chk(sleep_mode, 1'b1);
    {wev, ext_pin_irq_enable} = 7'h01;
    for (int i = 0; i < 6; i++) begin
      wev = 6'h01 << i;
      cyc(1);
      wev = 6'h00;
      chk(sleep_mode, 1'b0);
      wait_for(1, n);
      chk({wake_vector, wake_resume, core_run}, i[0] ? 3'h5 : 3'h3);
      chk(wake_vector_addr, 12'h006);
      if (i < 5) begin
        u_rwwc_core_model.exec(i[0] ? 4 : 3);
        {wen, ext_pin_irq_enable} = 7'h04 << i;
        u_rwwc_core_model.exec(0);
      end
    end
    wen = 6'h00;
    $display("wake-up test done");
    timer_counter_irq_enable = 1'b1;
    wr_tcc(8'hf0);
    u_rwwc_core_model.exec(1);
    chk(idle_mode, 1'b1);
    wait_for(1, n);
    chk({wake_vector, idle_mode}, 2'b10);
    timer_counter_irq_enable = 1'b0;
    $display("idle test done");
    watchdog_enable_bit = 1'b1;
    repeat (5) begin
      cyc(40);
      u_rwwc_core_model.exec(2);
    end
    chk({core_run, timeout_flag}, 2'b11);
    cyc(58);
    chk(core_run, 1'b1);
    cyc(10);
    chk({core_reset, timeout_flag}, 2'b10);
    watchdog_enable_bit = 1'b0;
    wait_for(0, n);
    watchdog_enable_bit = 1'b1;
    u_rwwc_core_model.exec(0);
    cyc(75);
    chk({timeout_flag, powerdown_flag}, 2'b00);
    watchdog_enable_bit = 1'b0;
    wait_for(0, n);
    chk({wake_vector, wake_resume}, 2'b00);
    $display("watchdog test done");
    reset_pin_b = 1'b0;
    cyc(2);
    chk({core_reset, io_float, core_run}, 3'b110);
    reset_pin_b = 1'b1;
    wait_for(0, n);
    chk(n inside {[8:12]}, 1'b1);
    {internal_rc_long, low_volt_reset} = 2'b11;
    cyc(3);
    chk(core_reset, 1'b0);
    low_volt_reset_en = 1'b1;
    cyc(2);
    chk(core_reset, 1'b1);
    low_volt_reset = 1'b0;
    wait_for(0, n);
    chk(n inside {[31:36]}, 1'b1);
    {internal_rc_osc, watchdog_prescale_en, watchdog_prescale_select} = 5'h09;
    watchdog_enable_bit = 1'b1;
    u_rwwc_core_model.exec(2);
    cyc(200);
    chk({core_run, timeout_flag}, 2'b11);
    cyc(70);
    chk({core_reset, timeout_flag}, 2'b10);
    wait_for(0, n);
    chk(n inside {[25:29]}, 1'b1);
    $display("reset source test done");
    end_sim();
  end
endmodule
